/* File: inc/sram_host_pkg.sv */
/*
  Constants, timing counts and state encoding for the host controller of
  the battery-backed byte-wide static RAM.
  Assumes a 20 MHz system clock; every count below but SYNC_DEPTH and GAP_CYC is derived from it.
*/
package sram_host_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int MEM_BYTES = 8192;
  localparam int SYNC_W = DATA_W + 1;
  localparam int WAIT_W = 4;
  localparam int REC_CNT_W = 20;

  // ==========================================================
  // Clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_KHZ = 20000;

  // ==========================================================
  // Pin timing in its own units
  localparam int STORE_PULSE_WIDTH_NS = 50;
  localparam int SELECT_PULSE_WIDTH_NS = 55;
  localparam int ACCESS_CYCLE_NS = 70;
  localparam int STROBE_TO_RELEASE_TIME_NS = 25;
  localparam int REC_MIN_MS = 40;
  localparam int REC_MAX_MS = 200;

  // ==========================================================
  // Timing in clock cycles, least times rounded up
  localparam int STORE_CYC = (STORE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_CYC = (SELECT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC = (STORE_CYC > SELECT_CYC) ? STORE_CYC : SELECT_CYC;
  localparam int ACCESS_CYC = (ACCESS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_DEPTH = 2;
  localparam int RD_LOW_CYC = ACCESS_CYC + SYNC_DEPTH;
  localparam int GAP_CYC = 1;
  localparam int REC_MIN_CYC = REC_MIN_MS * CLK_KHZ;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic STROBE_RST = 1'b1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_PWR = 3'h0,
    ST_IDLE = 3'h1,
    ST_WR_LOW = 3'h2,
    ST_WR_HOLD = 3'h3,
    ST_RD_LOW = 3'h4,
    ST_GAP = 3'h5
  } state_t;

endpackage

/* File: inc/sync_if.sv */
/*
  Carrier between the controller and its input synchroniser.
  Assumes raw holds pin levels from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

interface sync_if;
  import sram_host_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] synced;
  modport stage (input raw, output synced);
  modport user (output raw, input synced);
endinterface

`default_nettype wire

/* File: hdl/input_sync.sv */
/*
  Two flip-flop synchroniser for every pin the controller reads.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module input_sync
  import sram_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sync_if.stage sif
);

  // ==========================================================
  // Per-bit stages; the first stage feeds only the second
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta_reg[i] <= SYNC_RST[i];
          sync_reg[i] <= SYNC_RST[i];
        end else begin
          meta_reg[i] <= sif.raw[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_reg;

endmodule

`default_nettype wire

/* File: hdl/sram_host.sv */
/*
  Host-side controller that drives the 8192-byte battery-backed SRAM
  through its address, data, select, store-strobe and output-enable pins.
  Assumes an external supply monitor pin that is high while the memory
  supply is in tolerance, and a tristate buffer outside built from the
  byte_lines out/oe/in triple.
*/
// Overview of operation
// - The address stays unchanged from the start to the end of every cycle.
// - Select or store strobe goes high for a recovery interval before the next cycle.
// - Output enable stays high through writes so the two sides never both drive data.
// - Store strobe stays low at least 50 ns, select at least 55 ns, in a write.
`timescale 1ns/100ps
`default_nettype none

module sram_host
  import sram_host_pkg::*;
#(
  parameter logic [REC_CNT_W-1:0] REC_CYCLES = REC_CNT_W'(REC_MIN_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_fault,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] byte_location_lines,
  output logic [DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe,
  input wire logic [DATA_W-1:0] byte_lines_in,
  output logic sel_n,
  output logic store_n,
  output logic out_en_n,
  input wire logic supply_ok
);

  // ==========================================================
  // Declarations
  state_t state_reg, state_next;
  logic [WAIT_W-1:0] wait_cnt_reg;
  logic [REC_CNT_W-1:0] rec_cnt_reg;
  logic rec_done, pwr_ok_s, take, wait_last, abort;
  logic [DATA_W-1:0] data_s;
  logic req_ready_reg, rsp_valid_reg, rsp_fault_reg;
  logic [DATA_W-1:0] rsp_rdata_reg, data_out_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic data_oe_reg, sel_n_reg, store_n_reg, out_en_n_reg;

  // ==========================================================
  // Pin inputs through two flip-flops
  sync_if sif ();
  assign sif.raw = {supply_ok, byte_lines_in};
  assign pwr_ok_s = sif.synced[DATA_W];
  assign data_s = sif.synced[DATA_W-1:0];

  input_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .sif(sif)
  );

  // ==========================================================
  // Sequencer decisions
  assign take = req_valid && req_ready_reg;
  assign rec_done = (rec_cnt_reg == REC_CYCLES);
  assign abort = !pwr_ok_s && (state_reg == ST_WR_LOW || state_reg == ST_WR_HOLD ||
                               state_reg == ST_RD_LOW);

  // End of the timed part of the current state
  always_comb begin
    wait_last = 1'b0;
    case (state_reg)
      ST_WR_LOW: wait_last = (wait_cnt_reg == WAIT_W'(WR_LOW_CYC - 1));
      ST_RD_LOW: wait_last = (wait_cnt_reg == WAIT_W'(RD_LOW_CYC - 1));
      ST_GAP: wait_last = (wait_cnt_reg == WAIT_W'(GAP_CYC - 1));
      default: wait_last = 1'b0;
    endcase
  end

  // Next state; a supply drop overrides everything
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PWR: if (rec_done) begin
        state_next = ST_IDLE;
      end
      ST_IDLE: if (take) begin
        state_next = req_write ? ST_WR_LOW : ST_RD_LOW;
      end
      ST_WR_LOW: if (wait_last) begin
        state_next = ST_WR_HOLD;
      end
      ST_WR_HOLD: state_next = ST_GAP;
      ST_RD_LOW: if (wait_last) begin
        state_next = ST_GAP;
      end
      ST_GAP: if (wait_last) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_PWR;
    endcase
    if (!pwr_ok_s) begin
      state_next = ST_PWR;
    end
  end

  // ==========================================================
  // State and cycle counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_PWR;
      wait_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        wait_cnt_reg <= '0;
      end else begin
        wait_cnt_reg <= wait_cnt_reg + WAIT_W'(1);
      end
    end
  end

  // Recovery wait: restarts on every supply drop, saturates when done
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rec_cnt_reg <= '0;
    end else if (!pwr_ok_s) begin
      rec_cnt_reg <= '0;
    end else if (state_reg == ST_PWR && !rec_done) begin
      rec_cnt_reg <= rec_cnt_reg + REC_CNT_W'(1);
    end
  end

  // ==========================================================
  // Memory pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_reg <= ADDR_RST;
      data_out_reg <= DATA_RST;
      sel_n_reg <= STROBE_RST;
      store_n_reg <= STROBE_RST;
      out_en_n_reg <= STROBE_RST;
      data_oe_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && take) begin
        addr_reg <= req_addr;
        data_out_reg <= req_wdata;
      end
      // Select and strobe fall and rise together in a write
      sel_n_reg <= !(state_next == ST_WR_LOW || state_next == ST_RD_LOW);
      store_n_reg <= !(state_next == ST_WR_LOW);
      out_en_n_reg <= !(state_next == ST_RD_LOW);
      data_oe_reg <= (state_next == ST_WR_LOW || state_next == ST_WR_HOLD);
    end
  end

  // ==========================================================
  // User side answers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_fault_reg <= 1'b0;
      rsp_rdata_reg <= DATA_RST;
    end else begin
      req_ready_reg <= (state_next == ST_IDLE);
      rsp_valid_reg <= abort || (state_reg == ST_WR_HOLD) ||
                       (state_reg == ST_RD_LOW && wait_last);
      rsp_fault_reg <= abort;
      if (state_reg == ST_RD_LOW && wait_last && !abort) begin
        rsp_rdata_reg <= data_s;
      end
    end
  end

  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_fault = rsp_fault_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign byte_location_lines = addr_reg;
  assign byte_lines_out = data_out_reg;
  assign byte_lines_oe = data_oe_reg;
  assign sel_n = sel_n_reg;
  assign store_n = store_n_reg;
  assign out_en_n = out_en_n_reg;

  // ==========================================================
  // Checks
  sequence wr_low_s;
    !store_n_reg && !sel_n_reg && data_oe_reg ##1 !store_n_reg && !sel_n_reg;
  endsequence

  sequence wr_end_s;
    store_n_reg && sel_n_reg && data_oe_reg ##1 !data_oe_reg;
  endsequence

  property addr_steady_p;
    @(posedge sys_clk) disable iff (rst)
      !sel_n_reg && !$past(sel_n_reg) |-> $stable(addr_reg);
  endproperty

  chk_addr_stable: assert property (addr_steady_p)
    else $error("address moved during a cycle");

  chk_write_oe_high: assert property (@(posedge sys_clk) disable iff (rst)
    (!store_n_reg || data_oe_reg) |-> out_en_n_reg)
    else $error("output enable low while writing");

  chk_write_steps: assert property (@(posedge sys_clk) disable iff (rst || !pwr_ok_s)
    $fell(store_n_reg) |-> wr_low_s ##1 wr_end_s)
    else $error("write pulse shape wrong");

  chk_select_width: assert property (@(posedge sys_clk) disable iff (rst || !pwr_ok_s)
    $fell(sel_n_reg) |-> !sel_n_reg [*2])
    else $error("select pulse too short");

  chk_recovery_gap: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sel_n_reg) |=> sel_n_reg && store_n_reg)
    else $error("no recovery gap between cycles");

  chk_pwr_block: assert property (@(posedge sys_clk) disable iff (rst)
    !pwr_ok_s |=> sel_n_reg && store_n_reg && !data_oe_reg && !req_ready_reg)
    else $error("memory accessed during power failure");

  chk_no_early_access: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sel_n_reg) |-> rec_cnt_reg == REC_CYCLES)
    else $error("access before recovery delay elapsed");

  chk_rec_resume: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_PWR && rec_done && pwr_ok_s |=> req_ready_reg)
    else $error("access not resumed after recovery");

  chk_read_capture: assert property (@(posedge sys_clk) disable iff (rst || !pwr_ok_s)
    $fell(out_en_n_reg) |-> !sel_n_reg [*4] ##1 rsp_valid_reg && !rsp_fault_reg)
    else $error("read answer timing wrong");

  chk_abort_fault: assert property (@(posedge sys_clk) disable iff (rst)
    abort |=> rsp_valid_reg && rsp_fault_reg && sel_n_reg)
    else $error("aborted cycle not reported");

endmodule

`default_nettype wire

/* File: tb/sram_model.sv */
/*
  Behavioural model of the battery-backed byte-wide static RAM at its pins.
  Assumes the host's data drive and enable arrive apart; this model returns
  the resolved level of the data wire to everyone.
*/
`timescale 1ns/100ps
`default_nettype none

module sram_model
  import sram_host_pkg::*;
#(
  parameter int REC_NS = 800
) (
  input wire logic [ADDR_W-1:0] byte_location_lines,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic host_oe,
  input wire logic sel_n,
  input wire logic store_n,
  input wire logic out_en_n,
  input wire logic power_ok,
  input wire logic slow,
  output logic [DATA_W-1:0] byte_lines
);
  logic [DATA_W-1:0] mem [MEM_BYTES];
  logic live = 1'b0;
  logic valid = 1'b0;
  logic [DATA_W-1:0] last = 8'h00;
  wire writing = live && !sel_n && !store_n;
  wire reading = live && !sel_n && !out_en_n && store_n;
  wire drv = host_oe || (reading && valid);
  wire [DATA_W-1:0] val = host_oe ? host_data : mem[byte_location_lines];

  // ==========================================================
  // Supply watch: deselect at once, accept inputs after recovery
  always @(power_ok) begin
    live = 1'b0;
    if (power_ok) begin
      #(REC_NS);
      live = power_ok;
    end
  end

  // Store at the earlier rising strobe; a cut cycle stores nothing
  always @(negedge writing) begin
    if (live) mem[byte_location_lines] = byte_lines;
  end

  // Read data turns valid after a prompt or slow access
  always @(reading or byte_location_lines) begin
    valid = 1'b0;
    if (reading) valid <= #(slow ? 60 : 10) 1'b1;
  end

  // Released wire shows the inverse of its last driven level
  always @(val or drv) begin
    if (drv) last = val;
  end
  assign byte_lines = drv ? val : ~last;
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench for the SRAM host controller with a memory model.
  Assumes a 20 MHz clock and a shortened recovery count.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import sram_host_pkg::*;
  localparam int REC = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 13'h0000;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic power_ok = 1'b0;
  logic slow = 1'b0;
  logic req_ready, rsp_valid, rsp_fault, byte_lines_oe, sel_n, store_n, out_en_n;
  logic [DATA_W-1:0] rsp_rdata, byte_lines_out, byte_lines;
  logic [ADDR_W-1:0] byte_location_lines, held_addr, a;
  logic [DATA_W-1:0] shadow [MEM_BYTES];
  logic [9:0] exp_q [$];
  logic [9:0] note;
  logic prev_sel = 1'b1;
  int err_count = 0;
  int n_tests = 0;
  int seed = 99617;
  int wr_cnt = 0;
  int i;

  sram_host #(.REC_CYCLES(REC_CNT_W'(REC))) i_sram_host (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_fault(rsp_fault), .rsp_rdata(rsp_rdata),
    .byte_location_lines(byte_location_lines), .byte_lines_out(byte_lines_out),
    .byte_lines_oe(byte_lines_oe), .byte_lines_in(byte_lines), .sel_n(sel_n),
    .store_n(store_n), .out_en_n(out_en_n), .supply_ok(power_ok));

  sram_model i_sram_model (
    .byte_location_lines(byte_location_lines), .host_data(byte_lines_out),
    .host_oe(byte_lines_oe), .sel_n(sel_n), .store_n(store_n), .out_en_n(out_en_n),
    .power_ok(power_ok), .slow(slow), .byte_lines(byte_lines));

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  // ==========================================================
  // Comparison, verdict and request tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 200) check(16'h0001, 16'h0000);
  endtask

  // Issue one request and note its answer; flt cuts the supply at the take
  task automatic request(input logic wr, input logic [ADDR_W-1:0] ad,
                         input logic [DATA_W-1:0] d, input logic flt);
    wait_ready();
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = d;
    if (wr && !flt) shadow[ad] = d;
    exp_q.push_back({~wr, flt, wr ? 8'h00 : shadow[ad]});
    if (flt) power_ok = 1'b0;
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask

  // ==========================================================
  // Answer watcher takes the oldest note per answer, sampled mid-cycle
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0002, 16'h0000);
      else begin
        note = exp_q.pop_front();
        check({7'h00, rsp_fault, note[9] ? rsp_rdata : 8'h00}, {7'h00, note[8:0]});
      end
    end
  end

  // Pin discipline while the memory is selected
  always @(negedge sys_clk) begin
    if (!rst && sel_n === 1'b0 && prev_sel === 1'b0) begin
      check({3'h0, byte_location_lines}, {3'h0, held_addr});
    end
    if (!rst && sel_n === 1'b0 && store_n === 1'b0) begin
      check({15'h0000, out_en_n}, 16'h0001);
      wr_cnt++;
    end else if (wr_cnt > 0) begin
      if (power_ok) check({15'h0000, wr_cnt >= WR_LOW_CYC}, 16'h0001);
      wr_cnt = 0;
    end
    held_addr = byte_location_lines;
    prev_sel = sel_n;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    power_ok = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({15'h0000, req_ready}, 16'h0000);
    request(1'b1, 13'h0000, 8'hA5, 1'b0);
    request(1'b1, 13'h1FFF, 8'h5A, 1'b0);
    for (i = 0; i < 12; i++) begin
      a = ADDR_W'($random(seed));
      slow = i[0];
      request(1'b1, a, DATA_W'($random(seed)), 1'b0);
      request(1'b0, a, 8'h00, 1'b0);
    end
    // Supply lost during a write, then retention and return
    request(1'b1, 13'h0010, 8'hC3, 1'b0);
    request(1'b1, 13'h0010, 8'h3C, 1'b1);
    repeat (30) @(negedge sys_clk);
    power_ok = 1'b1;
    repeat (10) @(negedge sys_clk);
    check({15'h0000, req_ready}, 16'h0000);
    request(1'b0, 13'h0000, 8'h00, 1'b0);
    request(1'b0, 13'h1FFF, 8'h00, 1'b0);
    request(1'b0, a, 8'h00, 1'b0);
    request(1'b0, 13'h0010, 8'h00, 1'b0);
    repeat (20) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end

  // Watchdog cuts a hang short
  initial begin
    #(CLK_PERIOD_NS * 20000);
    err_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
